// ---- dv/tb.sv ----
`timescale 1ns/100ps
module tb;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [11:0] avs_address = 12'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [11:0] vdc_raw = 12'h0;
  logic [11:0] vdc_meas;
  logic motor_idle = 1'b0;
  logic fault_active = 1'b0;
  logic feedback_pulse = 1'b0;
  logic rotation_feedback_pin;
  logic brake_pin = 1'b0;
  logic brake_apply;
  pdc_pkg::pdc_speed_in_type speed_in = '0;
  logic [15:0] speed_ref;
  logic [11:0] mon_in [4] = '{12'h0, 12'h0, 12'h0, 12'h0};
  logic [11:0] monitor_pin_route;
  pdc_pkg::pdc_pad_ctrl_type pad_ctrl;
  logic [6:0] serial_rx_addr = 7'h0;
  logic serial_rx_addr_valid = 1'b0;
  logic serial_addr_hit;
  int bad_count = 0;
  int total_checks = 0;
  logic [15:0] lfsr = 16'h003a;
  logic [31:0] pin_m;
  logic [31:0] dev_m;
  logic [31:0] rd;
  logic [31:0] r;
  logic [6:0] ta;
  logic v;

  pdc_regs i_dut (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .vdc_raw(vdc_raw),
    .vdc_meas(vdc_meas),
    .motor_idle(motor_idle),
    .fault_active(fault_active),
    .feedback_pulse(feedback_pulse),
    .rotation_feedback_pin(rotation_feedback_pin),
    .brake_pin(brake_pin),
    .brake_apply(brake_apply),
    .speed_in(speed_in),
    .speed_ref(speed_ref),
    .second_monitor_output(mon_in[0]),
    .sense_out_phase_a(mon_in[1]),
    .sense_out_phase_b(mon_in[2]),
    .sense_out_phase_c(mon_in[3]),
    .monitor_pin_route(monitor_pin_route),
    .pad_ctrl(pad_ctrl),
    .serial_rx_addr(serial_rx_addr),
    .serial_rx_addr_valid(serial_rx_addr_valid),
    .serial_addr_hit(serial_addr_hit)
  );

  always #5 clk_sys = ~clk_sys;

  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function logic [31:0] rnd32();
    logic [15:0] h;
    lfsr = lfsr_step(lfsr);
    h = lfsr;
    lfsr = lfsr_step(lfsr);
    return {h, lfsr};
  endfunction

  function automatic logic [31:0] upd(input logic [31:0] o, input logic [31:0] d, input logic [31:0] m,
                                      input logic [3:0] be);
    logic [31:0] bm;
    bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & m;
    return (o & ~bm) | (d & bm);
  endfunction

  function automatic logic [15:0] exp_speed(input logic [1:0] k, input pdc_pkg::pdc_speed_in_type s);
    return (k == 2'h0) ? s.analog_level : (k == 2'h1) ? s.pwm_duty : (k == 2'h2) ? s.digital_cmd : s.pin_freq;
  endfunction

  function automatic logic exp_fault_fb(input logic [1:0] k, input logic last);
    return (k == 2'h1) ? 1'b1 : (k == 2'h2) ? 1'b0 : last;
  endfunction

  task check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task final_report();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // one avalon transfer, holds the request until waitrequest is seen low at an edge
  task bus_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] be,
                output logic [31:0] q);
    int n;
    logic w;
    n = 0;
    w = 1'b1;
    q = 32'h0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    while (w !== 1'b0 && n < 50) begin
      @(negedge clk_sys);
      w = avs_waitrequest;
      q = avs_readdata;
      @(posedge clk_sys);
      n++;
    end
    if (w !== 1'b0) begin
      bad_count++;
      $display("unexpected bus hang at %0t: waitrequest %h expected %h", $time, w, 1'b0);
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task reg_wr(input logic sel, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] n;
    logic [31:0] q;
    if (!sel) begin
      pin_m = upd(pin_m, d, pdc_pkg::PIN_CFG_MASK, be);
      bus_xfer(1'b1, pdc_pkg::PIN_CFG_ADDR, d, be, q);
    end else begin
      n = upd(dev_m, d, pdc_pkg::DEV_CFG_MASK, be);
      if (n[1:0] == 2'h3) n[1:0] = dev_m[1:0];
      dev_m = n;
      bus_xfer(1'b1, pdc_pkg::DEV_CFG_ADDR, d, be, q);
    end
  endtask

  task settle();
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task chk_regs();
    logic [31:0] q;
    bus_xfer(1'b0, pdc_pkg::PIN_CFG_ADDR, 32'h0, 4'hf, q);
    check(q, pin_m);
    bus_xfer(1'b0, pdc_pkg::DEV_CFG_ADDR, 32'h0, 4'hf, q);
    check(q, dev_m);
    settle();
    check(32'(pad_ctrl), 32'({pin_m[6], dev_m[27], dev_m[2], dev_m[4:3], dev_m[1:0]}));
  endtask

  initial begin
    repeat (50000) @(posedge clk_sys);
    bad_count++;
    final_report();
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(negedge clk_sys);
    check(32'(pad_ctrl), 32'h0);
    bus_xfer(1'b0, pdc_pkg::PIN_CFG_ADDR, 32'h0, 4'hf, rd);
    check(rd, 32'h0);
    bus_xfer(1'b0, pdc_pkg::DEV_CFG_ADDR, 32'h0, 4'hf, rd);
    check(rd & ~32'h07f0_0000, 32'h0);
    pin_m = 32'h0;
    dev_m = rd;
    // random register traffic with all-ones and reserved range corners
    for (int i = 0; i < 16; i++) begin
      r = rnd32();
      rd = rnd32();
      reg_wr(i[0], (i < 2) ? 32'hffff_ffff : r, (i < 2) ? 4'hf : rd[3:0]);
      chk_regs();
    end
    // unmapped place reads zero and ignores writes
    bus_xfer(1'b1, 12'h100, 32'hffff_ffff, 4'hf, rd);
    bus_xfer(1'b0, 12'h100, 32'h0, 4'hf, rd);
    check(rd, 32'h0);
    chk_regs();
    // rejected range write raises status bit 3, next good write clears it
    reg_wr(1'b1, dev_m | 32'h3, 4'h1);
    bus_xfer(1'b0, pdc_pkg::STATUS_ADDR, 32'h0, 4'hf, rd);
    check(rd & 32'h8, 32'h8);
    reg_wr(1'b1, dev_m, 4'hf);
    bus_xfer(1'b0, pdc_pkg::STATUS_ADDR, 32'h0, 4'hf, rd);
    check(rd & 32'h8, 32'h0);
    // every code of the two-bit selects
    for (int k = 0; k < 4; k++) begin
      reg_wr(1'b0, (k << 9) | (k << 7) | (k << 2) | k, 4'hf);
      reg_wr(1'b1, (dev_m & ~32'h3000_0000) | (k << 28), 4'hf);
      r = rnd32();
      rd = rnd32();
      @(posedge clk_sys);
      speed_in <= {r, rd};
      for (int j = 0; j < 4; j++) mon_in[j] <= 12'(rnd32());
      brake_pin <= r[0];
      feedback_pulse <= rd[1];
      motor_idle <= 1'b1;
      fault_active <= 1'b0;
      settle();
      check(32'(speed_ref), 32'(exp_speed(2'(k), speed_in)));
      check(32'(monitor_pin_route), 32'(mon_in[k]));
      check(32'(brake_apply), 32'((k == 1) ? 1'b1 : (k == 2) ? 1'b0 : brake_pin));
      check(32'(rotation_feedback_pin), 32'((k == 0) ? feedback_pulse : (k != 2)));
      v = r[2];
      @(posedge clk_sys);
      motor_idle <= 1'b0;
      feedback_pulse <= v;
      settle();
      @(posedge clk_sys);
      fault_active <= 1'b1;
      feedback_pulse <= ~v;
      settle();
      check(32'(rotation_feedback_pin), 32'(exp_fault_fb(2'(k), v)));
      @(posedge clk_sys);
      fault_active <= 1'b0;
    end
    // supply filter bypassed, then filtering a step from zero
    reg_wr(1'b0, 32'h0800_0000, 4'hf);
    r = rnd32();
    @(posedge clk_sys);
    vdc_raw <= r[11:0];
    settle();
    check(32'(vdc_meas), 32'(r[11:0]));
    @(posedge clk_sys);
    vdc_raw <= 12'h0;
    settle();
    reg_wr(1'b0, 32'h0, 4'hf);
    settle();
    check(32'(vdc_meas), 32'h0);
    @(posedge clk_sys);
    vdc_raw <= 12'h800;
    @(negedge clk_sys);
    @(negedge clk_sys);
    check(32'(vdc_meas), 32'h200);
    @(negedge clk_sys);
    check(32'(vdc_meas), 32'h380);
    // serial target address follows the written field
    r = rnd32();
    ta = r[6:0];
    reg_wr(1'b1, (dev_m & ~32'h07f0_0000) | (32'(ta) << 20), 4'hf);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      serial_rx_addr <= ta ^ 7'(k);
      serial_rx_addr_valid <= 1'b1;
      @(posedge clk_sys);
      serial_rx_addr_valid <= 1'b0;
      @(negedge clk_sys);
      check(32'(serial_addr_hit), 32'(k == 0));
      @(negedge clk_sys);
      check(32'(serial_addr_hit), 32'h0);
    end
    // clock enable low freezes the registered speed reference
    rd = 32'(speed_in.analog_level);
    check(32'(speed_ref), rd);
    @(posedge clk_sys);
    clk_en <= 1'b0;
    speed_in <= ~speed_in;
    settle();
    check(32'(speed_ref), rd);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    settle();
    check(32'(speed_ref), 32'(speed_in.analog_level));
    final_report();
  end
endmodule

// ---- verilog/pdc_addr_match.sv ----
`timescale 1ns/100ps
module pdc_addr_match (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [6:0] target_addr,
  input wire logic [6:0] rx_addr,
  input wire logic rx_addr_valid,
  output logic addr_hit
);

  logic next_addr_hit;

  // compare against the live target address field
  always_comb begin
    next_addr_hit = rx_addr_valid && (rx_addr == target_addr);
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      addr_hit <= 1'b0;
    end else if (clk_en) begin
      addr_hit <= next_addr_hit;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  chk_addr_hit_match: assert property (clk_en && rx_addr_valid && rx_addr == target_addr |=> addr_hit)
    else $error("serial address hit missed");
  chk_addr_hit_miss: assert property (clk_en && !(rx_addr_valid && rx_addr == target_addr) |=> !addr_hit)
    else $error("serial address hit without match");

endmodule

// ---- verilog/pdc_pkg.sv ----
package pdc_pkg;

  // register indices and byte addresses (byte address is four times the index)
  localparam logic [7:0] PIN_CFG_IDX = 8'ha4;
  localparam logic [7:0] DEV_CFG_IDX = 8'ha6;
  localparam logic [7:0] STATUS_IDX = 8'hb0;
  localparam logic [11:0] PIN_CFG_ADDR = {2'h0, PIN_CFG_IDX, 2'h0};
  localparam logic [11:0] DEV_CFG_ADDR = {2'h0, DEV_CFG_IDX, 2'h0};
  localparam logic [11:0] STATUS_ADDR = {2'h0, STATUS_IDX, 2'h0};

  // reset values and writable masks
  localparam logic [31:0] PIN_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] DEV_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] PIN_CFG_MASK = 32'h0800_07cf;
  localparam logic [31:0] DEV_CFG_MASK = 32'h3ff0_001f;
  // default serial target address, value is arbitrary
  localparam logic [6:0] TARGET_ADDR_RST = 7'h2a;

  // pin configuration field positions
  localparam int PIN_FILT_BYP_BIT = 27;
  localparam int PIN_IDLE_LSB = 9;
  localparam int PIN_FAULT_LSB = 7;
  localparam int PIN_ALARM_BIT = 6;
  localparam int PIN_BRAKE_LSB = 2;
  localparam int PIN_SPEED_LSB = 0;

  // device configuration field positions
  localparam int DEV_ROUTE_LSB = 28;
  localparam int DEV_DAC_EN_BIT = 27;
  localparam int DEV_ADDR_LSB = 20;
  localparam int DEV_DRIVE_LSB = 3;
  localparam int DEV_PULLUP_BIT = 2;
  localparam int DEV_RANGE_LSB = 0;

  // supply filter weight shift
  localparam int FILT_SHIFT = 2;

  // dc link range code that must not be stored
  localparam logic [1:0] RANGE_RESERVED = 2'h3;

  typedef enum logic [1:0] {
    SPD_ANALOG = 2'b00,
    SPD_PWM = 2'b01,
    SPD_DIGITAL = 2'b10,
    SPD_FREQ = 2'b11
  } pdc_speed_src_type;

  typedef enum logic [1:0] {
    FB_FOLLOW = 2'b00,
    FB_HIGH = 2'b01,
    FB_LOW = 2'b10,
    FB_HIGH_ALT = 2'b11
  } pdc_fb_mode_type;

  typedef enum logic [1:0] {
    BRK_PIN = 2'b00,
    BRK_LOW_SIDE = 2'b01,
    BRK_NONE = 2'b10,
    BRK_PIN_ALT = 2'b11
  } pdc_brake_mode_type;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } pdc_bus_state_type;

  typedef struct packed {
    logic [15:0] analog_level;
    logic [15:0] pwm_duty;
    logic [15:0] digital_cmd;
    logic [15:0] pin_freq;
  } pdc_speed_in_type;

  typedef struct packed {
    logic alarm_en;
    logic monitor_output_en;
    logic pullup_en;
    logic [1:0] serial_drive;
    logic [1:0] dc_link_range;
  } pdc_pad_ctrl_type;

endpackage

// ---- verilog/pdc_regs.sv ----
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module pdc_regs (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [11:0] vdc_raw,
  output logic [11:0] vdc_meas,
  input wire logic motor_idle,
  input wire logic fault_active,
  input wire logic feedback_pulse,
  output logic rotation_feedback_pin,
  input wire logic brake_pin,
  output logic brake_apply,
  input wire pdc_pkg::pdc_speed_in_type speed_in,
  output logic [15:0] speed_ref,
  input wire logic [11:0] second_monitor_output,
  input wire logic [11:0] sense_out_phase_a,
  input wire logic [11:0] sense_out_phase_b,
  input wire logic [11:0] sense_out_phase_c,
  output logic [11:0] monitor_pin_route,
  output pdc_pkg::pdc_pad_ctrl_type pad_ctrl,
  input wire logic [6:0] serial_rx_addr,
  input wire logic serial_rx_addr_valid,
  output logic serial_addr_hit
);

  // register file state
  pdc_pkg::pdc_bus_state_type bus_state;
  pdc_pkg::pdc_bus_state_type next_bus_state;
  logic [31:0] pin_function_config;
  logic [31:0] device_setup_primary;
  logic [31:0] next_pin_function_config;
  logic [31:0] next_device_setup_primary;
  logic [31:0] next_avs_readdata;
  logic range_reject;
  logic next_range_reject;
  logic wr_accept;
  logic [31:0] be_mask;
  logic [31:0] wr_pin;
  logic [31:0] wr_dev;
  logic [31:0] status_word;

  // datapath state
  logic [11:0] next_vdc_meas;
  logic [13:0] filt_sum;
  logic last_drive_level;
  logic next_last_drive_level;
  logic next_rotation_feedback_pin;
  logic next_brake_apply;
  logic [15:0] next_speed_ref;
  logic [11:0] next_monitor_pin_route;

  // decoded fields
  pdc_pkg::pdc_fb_mode_type idle_mode;
  pdc_pkg::pdc_fb_mode_type fault_mode;
  pdc_pkg::pdc_brake_mode_type brake_mode;
  pdc_pkg::pdc_speed_src_type speed_src;
  logic [1:0] route_sel;
  logic filt_bypass;

  function automatic logic [1:0] field2(input logic [31:0] word, input int lsb);
    field2 = word[lsb +: 2];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdata,
                                        input logic [31:0] bmask, input logic [31:0] wmask);
    merge = ((old & ~(bmask & wmask)) | (wdata & bmask & wmask)) & wmask;
  endfunction

  always_comb begin
    filt_bypass = pin_function_config[pdc_pkg::PIN_FILT_BYP_BIT];
    idle_mode = pdc_pkg::pdc_fb_mode_type'(field2(pin_function_config, pdc_pkg::PIN_IDLE_LSB));
    fault_mode = pdc_pkg::pdc_fb_mode_type'(field2(pin_function_config, pdc_pkg::PIN_FAULT_LSB));
    brake_mode = pdc_pkg::pdc_brake_mode_type'(field2(pin_function_config, pdc_pkg::PIN_BRAKE_LSB));
    speed_src = pdc_pkg::pdc_speed_src_type'(field2(pin_function_config, pdc_pkg::PIN_SPEED_LSB));
    route_sel = field2(device_setup_primary, pdc_pkg::DEV_ROUTE_LSB);
  end

  // avalon slave: one wait state, then answer
  always_comb begin
    avs_waitrequest = (avs_read || avs_write) && (bus_state == pdc_pkg::BUS_IDLE || !clk_en);
    wr_accept = avs_write && !avs_waitrequest && clk_en;
  end

  always_comb begin
    next_bus_state = bus_state;
    case (bus_state)
      pdc_pkg::BUS_IDLE: begin
        if (avs_read || avs_write) begin
          next_bus_state = pdc_pkg::BUS_ACK;
        end
      end
      pdc_pkg::BUS_ACK: begin
        next_bus_state = pdc_pkg::BUS_IDLE;
      end
      default: begin
        next_bus_state = pdc_pkg::BUS_IDLE;
      end
    endcase
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[0] = rotation_feedback_pin;
    status_word[1] = brake_apply;
    status_word[2] = last_drive_level;
    status_word[3] = range_reject;
    status_word[4] = serial_addr_hit;
  end

  // read data, unmapped addresses read zero
  always_comb begin
    next_avs_readdata = avs_readdata;
    if (avs_read && bus_state == pdc_pkg::BUS_IDLE) begin
      if (avs_address == pdc_pkg::PIN_CFG_ADDR) begin
        next_avs_readdata = pin_function_config & pdc_pkg::PIN_CFG_MASK;
      end else if (avs_address == pdc_pkg::DEV_CFG_ADDR) begin
        next_avs_readdata = device_setup_primary & pdc_pkg::DEV_CFG_MASK;
      end else if (avs_address == pdc_pkg::STATUS_ADDR) begin
        next_avs_readdata = status_word;
      end else begin
        next_avs_readdata = 32'h0000_0000;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_be
      assign be_mask[gi*8 +: 8] = {8{avs_byteenable[gi]}};
    end
  endgenerate

  // register writes with byte enables
  always_comb begin
    wr_pin = merge(pin_function_config, avs_writedata, be_mask, pdc_pkg::PIN_CFG_MASK);
    wr_dev = merge(device_setup_primary, avs_writedata, be_mask, pdc_pkg::DEV_CFG_MASK);
    next_pin_function_config = pin_function_config;
    next_device_setup_primary = device_setup_primary;
    next_range_reject = range_reject;
    if (wr_accept) begin
      if (avs_address == pdc_pkg::PIN_CFG_ADDR) begin
        next_pin_function_config = wr_pin;
      end else if (avs_address == pdc_pkg::DEV_CFG_ADDR) begin
        next_device_setup_primary = wr_dev;
        next_range_reject = 1'b0;
        if (field2(wr_dev, pdc_pkg::DEV_RANGE_LSB) == pdc_pkg::RANGE_RESERVED) begin
          next_device_setup_primary[pdc_pkg::DEV_RANGE_LSB +: 2] =
            device_setup_primary[pdc_pkg::DEV_RANGE_LSB +: 2];
          next_range_reject = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bus_state <= pdc_pkg::BUS_IDLE;
      avs_readdata <= 32'h0000_0000;
      pin_function_config <= pdc_pkg::PIN_CFG_RST;
      device_setup_primary <= pdc_pkg::DEV_CFG_RST | {5'h00, pdc_pkg::TARGET_ADDR_RST, 20'h00000};
      range_reject <= 1'b0;
    end else if (clk_en) begin
      bus_state <= next_bus_state;
      avs_readdata <= next_avs_readdata;
      pin_function_config <= next_pin_function_config;
      device_setup_primary <= next_device_setup_primary;
      range_reject <= next_range_reject;
    end
  end

  // supply filter: three quarters old plus one quarter new
  always_comb begin
    filt_sum = 14'({2'h0, vdc_meas} * 14'h3 + {2'h0, vdc_raw});
    if (filt_bypass) begin
      next_vdc_meas = vdc_raw;
    end else begin
      next_vdc_meas = filt_sum[pdc_pkg::FILT_SHIFT +: 12];
    end
  end

  // feedback pin: fault takes priority over idle
  always_comb begin
    next_last_drive_level = last_drive_level;
    next_rotation_feedback_pin = feedback_pulse;
    if (!fault_active && !motor_idle) begin
      next_last_drive_level = feedback_pulse;
    end
    if (fault_active) begin
      case (fault_mode)
        pdc_pkg::FB_FOLLOW: next_rotation_feedback_pin = last_drive_level;
        pdc_pkg::FB_HIGH: next_rotation_feedback_pin = 1'b1;
        pdc_pkg::FB_LOW: next_rotation_feedback_pin = 1'b0;
        default: next_rotation_feedback_pin = last_drive_level;
      endcase
    end else if (motor_idle) begin
      case (idle_mode)
        pdc_pkg::FB_FOLLOW: next_rotation_feedback_pin = feedback_pulse;
        pdc_pkg::FB_LOW: next_rotation_feedback_pin = 1'b0;
        default: next_rotation_feedback_pin = 1'b1;
      endcase
    end
  end

  // brake command selection
  always_comb begin
    case (brake_mode)
      pdc_pkg::BRK_LOW_SIDE: next_brake_apply = 1'b1;
      pdc_pkg::BRK_NONE: next_brake_apply = 1'b0;
      default: next_brake_apply = brake_pin;
    endcase
  end

  // speed reference source
  always_comb begin
    case (speed_src)
      pdc_pkg::SPD_ANALOG: next_speed_ref = speed_in.analog_level;
      pdc_pkg::SPD_PWM: next_speed_ref = speed_in.pwm_duty;
      pdc_pkg::SPD_DIGITAL: next_speed_ref = speed_in.digital_cmd;
      default: next_speed_ref = speed_in.pin_freq;
    endcase
  end

  // shared monitor pin route
  always_comb begin
    case (route_sel)
      2'h0: next_monitor_pin_route = second_monitor_output;
      2'h1: next_monitor_pin_route = sense_out_phase_a;
      2'h2: next_monitor_pin_route = sense_out_phase_b;
      default: next_monitor_pin_route = sense_out_phase_c;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      vdc_meas <= 12'h000;
      last_drive_level <= 1'b0;
      rotation_feedback_pin <= 1'b0;
      brake_apply <= 1'b0;
      speed_ref <= 16'h0000;
      monitor_pin_route <= 12'h000;
    end else if (clk_en) begin
      vdc_meas <= next_vdc_meas;
      last_drive_level <= next_last_drive_level;
      rotation_feedback_pin <= next_rotation_feedback_pin;
      brake_apply <= next_brake_apply;
      speed_ref <= next_speed_ref;
      monitor_pin_route <= next_monitor_pin_route;
    end
  end

  // pad and enable controls straight from register bits
  always_comb begin
    pad_ctrl.alarm_en = pin_function_config[pdc_pkg::PIN_ALARM_BIT];
    pad_ctrl.monitor_output_en = device_setup_primary[pdc_pkg::DEV_DAC_EN_BIT];
    pad_ctrl.pullup_en = device_setup_primary[pdc_pkg::DEV_PULLUP_BIT];
    pad_ctrl.serial_drive = field2(device_setup_primary, pdc_pkg::DEV_DRIVE_LSB);
    pad_ctrl.dc_link_range = field2(device_setup_primary, pdc_pkg::DEV_RANGE_LSB);
  end

  pdc_addr_match u_addr_match (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .target_addr(device_setup_primary[pdc_pkg::DEV_ADDR_LSB +: 7]),
    .rx_addr(serial_rx_addr),
    .rx_addr_valid(serial_rx_addr_valid),
    .addr_hit(serial_addr_hit)
  );

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence pin_wr_seq;
    wr_accept && avs_address == pdc_pkg::PIN_CFG_ADDR && avs_byteenable == 4'hf;
  endsequence

  sequence dev_wr_seq;
    wr_accept && avs_address == pdc_pkg::DEV_CFG_ADDR && avs_byteenable == 4'hf;
  endsequence

  chk_filter_bypass_path: assert property (clk_en && filt_bypass |=> vdc_meas == $past(vdc_raw))
    else $error("supply bypass not passing raw value");
  chk_filter_smooth: assert property (clk_en && !filt_bypass && vdc_raw == vdc_meas |=> vdc_meas == $past(vdc_raw))
    else $error("supply filter drifted at steady input");
  chk_idle_pin_level: assert property (clk_en && !fault_active && motor_idle && idle_mode == pdc_pkg::FB_LOW
    |=> !rotation_feedback_pin)
    else $error("idle feedback not held low");
  chk_fault_hold_level: assert property (clk_en && fault_active && fault_mode == pdc_pkg::FB_FOLLOW
    |=> rotation_feedback_pin == $past(last_drive_level))
    else $error("fault feedback not holding last driven level");
  chk_alarm_enable_write: assert property (pin_wr_seq |=> pad_ctrl.alarm_en == $past(avs_writedata[6]))
    else $error("alarm enable did not follow write");
  chk_brake_override: assert property (clk_en && brake_mode == pdc_pkg::BRK_LOW_SIDE ##1 clk_en && brake_mode == pdc_pkg::BRK_LOW_SIDE
    |=> brake_apply)
    else $error("low-side brake override not applied");
  chk_speed_digital: assert property (clk_en && speed_src == pdc_pkg::SPD_DIGITAL |=> speed_ref == $past(speed_in.digital_cmd))
    else $error("digital speed source not selected");
  chk_route_phase_b: assert property (clk_en && route_sel == 2'h2 |=> monitor_pin_route == $past(sense_out_phase_b))
    else $error("monitor route phase b wrong");
  chk_dac_enable_write: assert property (dev_wr_seq |=> pad_ctrl.monitor_output_en == $past(avs_writedata[27]))
    else $error("monitor enable did not follow write");
  chk_drive_code_write: assert property (dev_wr_seq |=> pad_ctrl.serial_drive == $past(avs_writedata[4:3]))
    else $error("drive code did not follow write");
  chk_pullup_write: assert property (dev_wr_seq |=> pad_ctrl.pullup_en == $past(avs_writedata[2]))
    else $error("pull-up enable did not follow write");
  chk_range_no_reserved: assert property (pad_ctrl.dc_link_range != pdc_pkg::RANGE_RESERVED)
    else $error("reserved dc link range stored");
  chk_reserved_read_zero: assert property (avs_read && !avs_waitrequest && avs_address == pdc_pkg::PIN_CFG_ADDR
    |-> (avs_readdata & ~pdc_pkg::PIN_CFG_MASK) == 32'h0000_0000)
    else $error("reserved pin config bits read nonzero");
  chk_wait_one_cycle: assert property (clk_en && (avs_read || avs_write) && bus_state == pdc_pkg::BUS_IDLE
    ##1 clk_en |-> !avs_waitrequest)
    else $error("bus answer not after one wait state");

  cov_pin_write: cover property (pin_wr_seq);
  cov_dev_range_reject: cover property (dev_wr_seq ##1 range_reject);
  cov_fault_hold: cover property (fault_active && fault_mode == pdc_pkg::FB_FOLLOW && last_drive_level);
  cov_addr_hit: cover property (serial_addr_hit);

endmodule
